// [dit_pkg.sv]
// ==========================================
// shared constants for both ends of the link
package dit_pkg;
    // clock and serial clock timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_PERIOD_NS = 800;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [3:0] SCL_QUARTER_LAST = 4'(SCL_QUARTER_CYC - 1);
    // clocks in one address+command+two data byte frame
    localparam int FRAME_CLOCKS = 36;
    localparam int DATA_W = 16;
    // address byte layout
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [6:0] BCAST_ADDR = 7'h47;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] GC_RESET_CMD = 8'h06;
    // low address bits by strap of the select pin
    localparam logic [2:0] STRAP_GND = 3'h0;
    localparam logic [2:0] STRAP_VDD = 3'h1;
    localparam logic [2:0] STRAP_SDA = 3'h2;
    localparam logic [2:0] STRAP_SCL = 3'h3;
    // bit slot of the acknowledge within a byte
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // byte positions within a frame
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_CMD = 2'h1;
    localparam logic [1:0] IDX_HIGH = 2'h2;
    localparam logic [1:0] IDX_LOW = 2'h3;
    // controller byte sequence markers
    localparam logic [2:0] WR_LAST = 3'h3;
    localparam logic [2:0] RD_LAST = 3'h4;
    localparam logic [2:0] GC_LAST = 3'h1;
    localparam logic [2:0] RD_DATA_IDX = 3'h3;
    typedef enum logic [1:0] {DIT_OP_WRITE, DIT_OP_READ, DIT_OP_GCRESET} dit_op_t;
endpackage

// [dit_if.sv]
`timescale 1ns/1ns
// ==========================================
// two-wire bus, open drain with pull-ups
interface dit_if;
    logic ctl_scl_o;
    logic ctl_scl_oe_n;
    logic ctl_sda_o;
    logic ctl_sda_oe_n;
    logic tgt_sda_o;
    logic tgt_sda_oe_n;
    logic scl;
    logic sda;
    // wired-and: a line is low while anyone pulls it
    assign scl = !(!ctl_scl_oe_n && !ctl_scl_o);
    assign sda = !((!ctl_sda_oe_n && !ctl_sda_o) || (!tgt_sda_oe_n && !tgt_sda_o));
    modport ctl (output ctl_scl_o, ctl_scl_oe_n, ctl_sda_o, ctl_sda_oe_n, input scl, sda);
    modport tgt (output tgt_sda_o, tgt_sda_oe_n, input scl, sda);
endinterface

// [dit_target.sv]
`timescale 1ns/1ns
// ==========================================
// target end: address match, write/update, read
// Overview of operation
// [RULE1] controller sends start, address, command, two data
// [RULE2] target pulls data low through ack high
// [RULE3] four bytes plus acks are 36 clocks
// [RULE4] command first, then high then low data
// [RULE5] update on falling edge ending low ack
// [RULE6] stop releases data line, wait for start
// [RULE7] upper address bits must be 1001
// [RULE8] select pin strap sets lower three bits
// [RULE9] strap sampled during first byte, then latched
// [RULE10] broadcast write address accepted regardless of strap
// [RULE11] broadcast address never answered for reads
// [RULE12] read: address, command, repeated start, address
// [RULE13] target sends high byte, then low byte
// [RULE14] address acked only when it matches
// [RULE15] general call 00, 06 gives soft reset
// [RULE16] partial write dropped, nothing updated; here cmd_sel still takes the command byte of a partial write
module dit_target (
    input wire logic clk,
    input wire logic rst,
    dit_if.tgt bus,
    input wire logic addr_select_pin,
    input wire logic [dit_pkg::DATA_W-1:0] rd_data,
    output logic dac_update,
    output logic [7:0] cmd_sel,
    output logic [dit_pkg::DATA_W-1:0] upd_data,
    output logic soft_reset
);
    import dit_pkg::*;

    typedef enum logic [2:0] {T_IDLE, T_RX, T_ACK, T_TX, T_TXACK, T_SKIP} dit_tstate_t;

    // ==========================================
    // synchronisers and line events
    logic [2:0] scl_sh_reg;
    logic [2:0] sda_sh_reg;
    logic [1:0] pin_sh_reg;

    // two flops before use, third only for edges
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sh_reg <= 3'h7;
            sda_sh_reg <= 3'h7;
            pin_sh_reg <= 2'h0;
        end else begin
            scl_sh_reg <= {scl_sh_reg[1:0], bus.scl};
            sda_sh_reg <= {sda_sh_reg[1:0], bus.sda};
            pin_sh_reg <= {pin_sh_reg[0], addr_select_pin};
        end
    end

    wire scl_s = scl_sh_reg[1];
    wire sda_s = sda_sh_reg[1];
    wire pin_s = pin_sh_reg[1];
    wire scl_rise = scl_s & ~scl_sh_reg[2];
    wire scl_fall = ~scl_s & scl_sh_reg[2];
    wire scl_steady_hi = scl_s & scl_sh_reg[2];
    wire start_ev = scl_steady_hi & sda_sh_reg[2] & ~sda_s;
    wire stop_ev = scl_steady_hi & ~sda_sh_reg[2] & sda_s;

    // ==========================================
    // frame state
    dit_tstate_t state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_reg;
    logic [1:0] idx_reg;
    logic rw_reg;
    logic gc_reg;
    logic gc_arm_reg;
    logic ack_ok_reg;
    logic lo_sent_reg;
    logic [7:0] hi_reg;
    logic [15:0] tx_reg;
    logic sda_oe_n_reg;
    logic sda_o_reg;
    logic seen_hi_reg;
    logic seen_lo_reg;
    logic ne_sda_reg;
    logic [2:0] strap_reg;
    logic dac_update_reg;
    logic [7:0] cmd_reg;
    logic [15:0] upd_data_reg;
    logic soft_reset_reg;

    // ==========================================
    // strap decode: pin level versus the bus lines
    wire [2:0] strap_w = !seen_hi_reg ? STRAP_GND :
                         !seen_lo_reg ? STRAP_VDD :
                         !ne_sda_reg ? STRAP_SDA : STRAP_SCL; // [RULE8]
    wire strap_window = (state_reg == T_RX) && (idx_reg == IDX_ADDR);

    // watch pin only during the address byte
    always_ff @(posedge clk) begin
        if (rst || start_ev) begin
            seen_hi_reg <= 1'b0;
            seen_lo_reg <= 1'b0;
            ne_sda_reg <= 1'b0;
        end else if (strap_window) begin
            seen_hi_reg <= seen_hi_reg | pin_s; // [RULE9]
            seen_lo_reg <= seen_lo_reg | ~pin_s;
            ne_sda_reg <= ne_sda_reg | (pin_s ^ sda_s);
        end
    end

    // ==========================================
    // address and byte decisions
    wire [6:0] own_addr = {ADDR_FIXED, strap_w}; // [RULE7]
    wire gen_hit = shift_reg[7:1] == own_addr; // [RULE14]
    wire bc_hit = (shift_reg[7:1] == BCAST_ADDR) && !shift_reg[0]; // [RULE10] [RULE11]
    wire gc_hit = shift_reg == GC_ADDR;
    wire gc_cmd = shift_reg == GC_RESET_CMD;
    wire byte_end = scl_fall && (bit_reg == ACK_SLOT);

    // ==========================================
    // byte engine; the target only moves data on its seen falls
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= T_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 4'h0;
            idx_reg <= IDX_ADDR;
            rw_reg <= 1'b0;
            gc_reg <= 1'b0;
            gc_arm_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            lo_sent_reg <= 1'b0;
            hi_reg <= 8'h00;
            tx_reg <= 16'h0000;
            sda_oe_n_reg <= 1'b1;
            strap_reg <= STRAP_GND;
            dac_update_reg <= 1'b0;
            cmd_reg <= 8'h00;
            upd_data_reg <= 16'h0000;
            soft_reset_reg <= 1'b0;
        end else begin
            dac_update_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            if (stop_ev) begin
                state_reg <= T_IDLE; // [RULE6]
                sda_oe_n_reg <= 1'b1;
                gc_arm_reg <= 1'b0;
            end else if (start_ev) begin
                // repeated start also lands here; partial data is dropped
                state_reg <= T_RX; // [RULE16]
                sda_oe_n_reg <= 1'b1;
                bit_reg <= 4'h0;
                idx_reg <= IDX_ADDR;
                gc_reg <= 1'b0;
                gc_arm_reg <= 1'b0;
            end else begin
                case (state_reg)
                    T_RX: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_reg <= bit_reg + 4'h1;
                        end else if (byte_end) begin
                            bit_reg <= 4'h0;
                            state_reg <= T_ACK;
                            sda_oe_n_reg <= 1'b0; // [RULE2]
                            case (idx_reg)
                                IDX_ADDR: begin
                                    strap_reg <= strap_w;
                                    rw_reg <= shift_reg[0];
                                    gc_reg <= gc_hit;
                                    if (!(gen_hit || bc_hit || gc_hit)) begin
                                        state_reg <= T_SKIP; // [RULE14]
                                        sda_oe_n_reg <= 1'b1;
                                    end
                                end
                                IDX_CMD: begin
                                    if (gc_reg) begin
                                        gc_arm_reg <= gc_cmd;
                                        if (!gc_cmd) begin
                                            state_reg <= T_SKIP;
                                            sda_oe_n_reg <= 1'b1;
                                        end
                                    end else begin
                                        cmd_reg <= shift_reg; // [RULE4]
                                    end
                                end
                                IDX_HIGH: hi_reg <= shift_reg; // [RULE4]
                                default: ;
                            endcase
                        end
                    end
                    T_ACK: begin
                        if (scl_rise && gc_arm_reg) begin
                            soft_reset_reg <= 1'b1; // [RULE15]
                            gc_arm_reg <= 1'b0;
                        end
                        if (scl_fall) begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= T_RX;
                            idx_reg <= idx_reg + 2'h1;
                            if (gc_reg && idx_reg == IDX_CMD) begin
                                state_reg <= T_SKIP;
                            end else if (rw_reg && idx_reg == IDX_ADDR) begin
                                // read address acked: first bit out now
                                state_reg <= T_TX; // [RULE12]
                                idx_reg <= IDX_CMD;
                                tx_reg <= rd_data;
                                lo_sent_reg <= 1'b0;
                                sda_oe_n_reg <= rd_data[15]; // [RULE13]
                            end else if (idx_reg == IDX_LOW) begin
                                // streaming: next pair reuses the command
                                dac_update_reg <= 1'b1; // [RULE5] [RULE3]
                                upd_data_reg <= {hi_reg, shift_reg};
                                idx_reg <= IDX_HIGH;
                            end
                        end
                    end
                    T_TX: begin
                        if (scl_rise) begin
                            bit_reg <= bit_reg + 4'h1;
                        end else if (scl_fall && bit_reg != 4'h0) begin
                            tx_reg <= {tx_reg[14:0], 1'b0};
                            if (bit_reg == ACK_SLOT) begin
                                sda_oe_n_reg <= 1'b1;
                                bit_reg <= 4'h0;
                                state_reg <= T_TXACK;
                            end else begin
                                sda_oe_n_reg <= tx_reg[14]; // [RULE13]
                            end
                        end
                    end
                    T_TXACK: begin
                        if (scl_rise) begin
                            ack_ok_reg <= ~sda_s;
                        end else if (scl_fall) begin
                            if (ack_ok_reg && !lo_sent_reg) begin
                                state_reg <= T_TX; // [RULE13]
                                lo_sent_reg <= 1'b1;
                                sda_oe_n_reg <= tx_reg[15];
                            end else begin
                                state_reg <= T_SKIP;
                            end
                        end
                    end
                    // idle and skip: line released, wait for start or stop
                    default: sda_oe_n_reg <= 1'b1;
                endcase
            end
        end
    end

    // open drain: the pin value is always low, only the enable moves
    always_ff @(posedge clk) begin
        sda_o_reg <= 1'b0;
    end

    // ==========================================
    // outputs
    assign bus.tgt_sda_oe_n = sda_oe_n_reg;
    assign bus.tgt_sda_o = sda_o_reg;
    assign dac_update = dac_update_reg;
    assign cmd_sel = cmd_reg;
    assign upd_data = upd_data_reg;
    assign soft_reset = soft_reset_reg;
endmodule

// [dit_controller.sv]
`timescale 1ns/1ns
// ==========================================
// controller end: makes the serial clock and frames
module dit_controller (
    input wire logic clk,
    input wire logic rst,
    dit_if.ctl bus,
    input wire logic start,
    input wire dit_pkg::dit_op_t op,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] cmd,
    input wire logic [dit_pkg::DATA_W-1:0] wdata,
    output logic busy,
    output logic done,
    output logic nack,
    output logic [dit_pkg::DATA_W-1:0] rdata
);
    import dit_pkg::*;

    typedef enum logic [2:0] {C_IDLE, C_START, C_BIT, C_RSTART, C_STOP} dit_cstate_t;

    // ==========================================
    // quarter-period divider and data line sync
    logic [3:0] qcnt_reg;
    logic [1:0] ph_reg;
    logic [1:0] sda_sh_reg;
    dit_cstate_t state_reg;
    wire tick = qcnt_reg == SCL_QUARTER_LAST;

    always_ff @(posedge clk) begin
        if (rst || state_reg == C_IDLE) begin
            qcnt_reg <= 4'h0;
            ph_reg <= 2'h0;
        end else begin
            qcnt_reg <= tick ? 4'h0 : qcnt_reg + 4'h1;
            ph_reg <= tick ? ph_reg + 2'h1 : ph_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sda_sh_reg <= 2'h3;
        end else begin
            sda_sh_reg <= {sda_sh_reg[0], bus.sda};
        end
    end

    wire sda_s = sda_sh_reg[1];

    // ==========================================
    // frame registers
    logic [2:0] idx_reg;
    logic [3:0] bit_reg;
    dit_op_t op_reg;
    logic [6:0] addr_reg;
    logic [7:0] cmd_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rx_reg;
    logic scl_oe_n_reg;
    logic sda_oe_n_reg;
    logic pin_o_reg;
    logic busy_reg;
    logic done_reg;
    logic nack_reg;

    // ==========================================
    // byte to send at each position of the frame
    wire is_rd = op_reg == DIT_OP_READ;
    wire is_gc = op_reg == DIT_OP_GCRESET;
    wire [2:0] last_idx = is_gc ? GC_LAST : is_rd ? RD_LAST : WR_LAST;
    wire rxing = is_rd && idx_reg >= RD_DATA_IDX;
    wire [7:0] tx_byte = (idx_reg == 3'h0) ? (is_gc ? GC_ADDR : {addr_reg, 1'b0}) : // [RULE1]
                         (idx_reg == 3'h1) ? (is_gc ? GC_RESET_CMD : cmd_reg) :
                         (idx_reg == 3'h2) ? (is_rd ? {addr_reg, 1'b1} : wdata_reg[15:8]) :
                         wdata_reg[7:0]; // [RULE4]
    wire [2:0] bsel = 3'h7 - bit_reg[2:0];
    wire ack_slot = bit_reg == ACK_SLOT;
    // last read byte gets a no-acknowledge to end the read
    wire ack_drive = rxing ? (idx_reg == last_idx) : 1'b1;

    // ==========================================
    // sequencer: one step per quarter of a bus clock
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= C_IDLE;
            idx_reg <= 3'h0;
            bit_reg <= 4'h0;
            op_reg <= DIT_OP_WRITE;
            addr_reg <= 7'h00;
            cmd_reg <= 8'h00;
            wdata_reg <= 16'h0000;
            rx_reg <= 16'h0000;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                C_IDLE: begin
                    if (start) begin
                        state_reg <= C_START;
                        op_reg <= op;
                        addr_reg <= dev_addr;
                        cmd_reg <= cmd;
                        wdata_reg <= wdata;
                        busy_reg <= 1'b1;
                        nack_reg <= 1'b0;
                        idx_reg <= 3'h0;
                        bit_reg <= 4'h0;
                    end
                end
                C_START: if (tick) begin
                    // data falls while clock high, then clock falls
                    if (ph_reg == 2'h0) sda_oe_n_reg <= 1'b0;
                    if (ph_reg == 2'h2) scl_oe_n_reg <= 1'b0;
                    if (ph_reg == 2'h3) state_reg <= C_BIT;
                end
                C_RSTART: if (tick) begin
                    if (ph_reg == 2'h0) sda_oe_n_reg <= 1'b1;
                    if (ph_reg == 2'h1) scl_oe_n_reg <= 1'b1;
                    if (ph_reg == 2'h2) sda_oe_n_reg <= 1'b0; // [RULE12]
                    if (ph_reg == 2'h3) begin
                        scl_oe_n_reg <= 1'b0;
                        state_reg <= C_BIT;
                    end
                end
                C_BIT: if (tick) begin
                    case (ph_reg)
                        2'h0: sda_oe_n_reg <= ack_slot ? ack_drive : (rxing | tx_byte[bsel]);
                        2'h1: scl_oe_n_reg <= 1'b1;
                        2'h2: begin
                            if (!ack_slot && rxing) rx_reg <= {rx_reg[14:0], sda_s}; // [RULE13]
                            if (ack_slot && !rxing && sda_s) nack_reg <= 1'b1; // [RULE2]
                        end
                        default: begin
                            scl_oe_n_reg <= 1'b0;
                            bit_reg <= ack_slot ? 4'h0 : bit_reg + 4'h1;
                            if (ack_slot) begin
                                // nine clocks per byte: four bytes give 36
                                if (nack_reg || idx_reg == last_idx) begin
                                    state_reg <= C_STOP; // [RULE3]
                                end else begin
                                    idx_reg <= idx_reg + 3'h1;
                                    if (is_rd && idx_reg == 3'h1) state_reg <= C_RSTART;
                                end
                            end
                        end
                    endcase
                end
                C_STOP: if (tick) begin
                    if (ph_reg == 2'h0) sda_oe_n_reg <= 1'b0;
                    if (ph_reg == 2'h1) scl_oe_n_reg <= 1'b1;
                    if (ph_reg == 2'h2) sda_oe_n_reg <= 1'b1;
                    if (ph_reg == 2'h3) begin
                        state_reg <= C_IDLE;
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                    end
                end
                default: state_reg <= C_IDLE;
            endcase
        end
    end

    // open drain: only the enables move
    always_ff @(posedge clk) begin
        pin_o_reg <= 1'b0;
    end

    // ==========================================
    // outputs
    assign bus.ctl_scl_o = pin_o_reg;
    assign bus.ctl_sda_o = pin_o_reg;
    assign bus.ctl_scl_oe_n = scl_oe_n_reg;
    assign bus.ctl_sda_oe_n = sda_oe_n_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign nack = nack_reg;
    assign rdata = rx_reg;
endmodule

// [dit_properties.sv]
`timescale 1ns/1ns
// ==========================================
// wire-level checks beside the link
module dit_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic tgt_sda_oe_n
);
    logic scl_d_reg;
    logic sda_d_reg;
    logic ack_seen_reg;
    logic rd_dir_reg;
    logic [7:0] sh_reg;
    logic [5:0] cnt_reg;
    // ==========================================
    // conditions decoded on the raw lines
    wire scl_rise = scl && !scl_d_reg;
    wire start_c = scl && scl_d_reg && sda_d_reg && !sda;
    wire stop_c = scl && scl_d_reg && !sda_d_reg && sda;
    wire addr_slot = scl_rise && cnt_reg == 6'h08;
    // clock pulses since the last start
    always_ff @(posedge clk) begin
        scl_d_reg <= scl;
        sda_d_reg <= sda;
        if (rst || start_c) begin
            cnt_reg <= 6'h00;
        end else if (scl_rise) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end
    // first byte and its answer; sda sampled on scl rise only
    always_ff @(posedge clk) begin
        if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda};
        end
        if (rst) begin
            ack_seen_reg <= 1'b0;
            rd_dir_reg <= 1'b0;
        end else if (addr_slot) begin
            ack_seen_reg <= !sda;
            rd_dir_reg <= sh_reg[0];
        end
    end
    // ==========================================
    // wire-level properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ack_stable_a: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe_n))
        else $error("target data line moved while clock high");
    data_valid_a: assert property (scl && scl_d_reg && sda != sda_d_reg |-> tgt_sda_oe_n)
        else $error("data edge under high clock while target drives");
    stop_release_a: assert property (stop_c |=> tgt_sda_oe_n [*8])
        else $error("target pulls data line after stop");
    frame_len_a: assert property (stop_c && ack_seen_reg |-> cnt_reg inside {6'h13, 6'h1c, 6'h25})
        else $error("clock pulse count per frame wrong");
    foreign_nack_a: assert property (addr_slot && sh_reg[7:4] != 4'h9 && sh_reg != 8'h8e
        && sh_reg != 8'h00 |-> sda)
        else $error("foreign address acknowledged");
    bcast_read_a: assert property (addr_slot && sh_reg == 8'h8f |-> sda)
        else $error("broadcast read acknowledged");
    bcast_ack_a: assert property (addr_slot && sh_reg == 8'h8e |-> !sda)
        else $error("broadcast write not acknowledged");
    data_ack_a: assert property (scl_rise && ack_seen_reg && !rd_dir_reg
        && (cnt_reg == 6'h11 || cnt_reg == 6'h1a || cnt_reg == 6'h23) |-> !sda)
        else $error("written byte not acknowledged");
    ack_release_a: assert property (scl_rise && cnt_reg == 6'h09 && ack_seen_reg
        && !rd_dir_reg |-> tgt_sda_oe_n)
        else $error("acknowledge held past one pulse");
    cover property (stop_c && ack_seen_reg && cnt_reg == 6'h25);
    cover property (addr_slot && sh_reg == 8'h8f);
    cover property (addr_slot && sh_reg[0] && !sda);
endmodule

// [tb.sv]
`timescale 1ns/1ns
// ==========================================
// link bench: controller and target face to face
module tb;
    import dit_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    dit_op_t op = DIT_OP_WRITE;
    logic [6:0] dev_addr = 7'h00;
    logic [7:0] cmd = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rd_data = 16'h3c5a;
    logic [1:0] strap = 2'h0;
    logic busy, done, nack, dac_update, soft_reset, sel_pin;
    logic [15:0] rdata, upd_data;
    logic [7:0] cmd_sel;
    int bad_count = 0;
    int tests_run = 0;
    int upd_cnt = 0;
    int rst_cnt = 0;
    dit_if bus_if();
    // strap choice: ground, supply, data line, clock line
    assign sel_pin = (strap == 2'h0) ? 1'b0 : (strap == 2'h1) ? 1'b1 : (strap == 2'h2) ? bus_if.sda : bus_if.scl;
    dit_target i_dit_target (.clk(clk), .rst(rst), .bus(bus_if), .addr_select_pin(sel_pin), .rd_data(rd_data),
        .dac_update(dac_update), .cmd_sel(cmd_sel), .upd_data(upd_data), .soft_reset(soft_reset));
    dit_controller i_dit_controller (.clk(clk), .rst(rst), .bus(bus_if), .start(start), .op(op),
        .dev_addr(dev_addr), .cmd(cmd), .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
    dit_properties i_dit_properties (.clk(clk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
        .tgt_sda_oe_n(bus_if.tgt_sda_oe_n));
    // 20 MHz clock
    always #25 clk = ~clk;
    // pulse counters, since both outputs last one cycle
    always @(posedge clk) begin
        if (dac_update === 1'b1) upd_cnt++;
        if (soft_reset === 1'b1) rst_cnt++;
    end
    // ==========================================
    // tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one frame; start held for a single edge, done awaited under a bound
    task automatic run(input dit_op_t o, input logic [1:0] s, input logic [6:0] a, input logic [7:0] c,
                       input logic [15:0] d, input logic en, input int eu);
        int u0;
        int n;
        u0 = upd_cnt;
        n = 0;
        strap = s;
        op = o;
        dev_addr = a;
        cmd = c;
        wdata = d;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check("busy", {15'h0000, busy}, 16'h0001);
        while (done !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) bad_count++;
        check("nack", {15'h0000, nack}, {15'h0000, en});
        check("updates", 16'(upd_cnt - u0), 16'(eu));
        if (eu > 0) check("upd_data", upd_data, d);
    endtask
    task automatic finish_test;
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // sequence
    initial begin
        int r0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        for (int s = 0; s < 4; s++) begin
            run(DIT_OP_WRITE, 2'(s), {4'h9, 3'(s)}, 8'h10 + 8'(s), 16'ha5c3 + 16'(s), 1'b0, 1);
            check("cmd_sel", {8'h00, cmd_sel}, {8'h00, 8'h10 + 8'(s)});
        end
        run(DIT_OP_WRITE, 2'h0, 7'h49, 8'h11, 16'h1234, 1'b1, 0);
        run(DIT_OP_WRITE, 2'h1, 7'h29, 8'h11, 16'h1234, 1'b1, 0);
        run(DIT_OP_WRITE, 2'h2, 7'h47, 8'h30, 16'h0ff0, 1'b0, 1);
        run(DIT_OP_READ, 2'h3, 7'h47, 8'h30, 16'h0000, 1'b1, 0);
        run(DIT_OP_READ, 2'h1, 7'h49, 8'h22, 16'h0000, 1'b0, 0);
        check("rdata", rdata, 16'h3c5a);
        r0 = rst_cnt;
        run(DIT_OP_GCRESET, 2'h0, 7'h00, 8'h06, 16'h0000, 1'b0, 0);
        check("soft_reset", 16'(rst_cnt - r0), 16'h0001);
        finish_test;
    end
    // hang guard, far beyond ten frames
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        finish_test;
    end
endmodule
